// ### hw/cfsc_top.sv
// Purpose: fieldbus command word intake and state word output for a
//          grid converter unit
// Assumes: received words arrive with RX_VALID, synchronous to CLK
// Notes:   the effective command word drives the unit-side outputs
`timescale 1ns/1ps

module cfsc_top #(
  parameter int DATA_W = cfsc_pkg::WORD_W,
  parameter int VEND_N = cfsc_pkg::VEND_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic RX_VALID,
  input wire logic [DATA_W-1:0] RX_WORD,
  input wire logic WD_FAULT,
  input wire logic PU_READY,
  input wire logic RUNNING,
  input wire logic FAULT,
  input wire logic WARNING,
  input wire logic FB_PLACE,
  input wire logic RUN_EN_IN,
  output logic [DATA_W-1:0] CMD_WORD,
  output logic [DATA_W-1:0] STATE_WORD,
  output logic WD_TOGGLE,
  output logic [VEND_N-1:0] VENDOR_FN,
  output logic RUN_PERMIT,
  output logic BREAKER_PERMIT,
  output logic QSTOP_REQ,
  output logic EVENT_RESET,
  output logic READY_OUT
);

  // the word layout is fixed, so only the documented geometry is served
  if (DATA_W != 16) begin : g_chk_width
    $error("cfsc_top: DATA_W must be 16");
  end
  if (VEND_N < 1 || VEND_N > 4) begin : g_chk_vend
    $error("cfsc_top: VEND_N must be 1 to 4");
  end

  logic [15:0] cmd_w;              // effective command word
  logic [15:0] state_w;            // registered state word
  logic wd_w;                      // latest watchdog bit
  cfsc_pkg::cfsc_unit_t unit_w;    // unit status bundle
  logic evt_prev_r;                // bit 7 one cycle back
  logic evt_prev_nxt;
  logic evt_pulse_r;               // event reset strobe
  logic evt_pulse_nxt;
  logic ready_r;                   // ready digital output
  logic ready_nxt;

  // only the command word passes the data-valid gate; no other
  // process data exists in this block, so nothing else is held
  cfsc_cmd_gate u_gate (
    .clk(CLK),
    .rst(RESET),
    .ce(CE),
    .rx_valid(RX_VALID),
    .rx_word(RX_WORD[15:0]),
    .wd_fault(WD_FAULT),
    .cmd_word(cmd_w),
    .wd_toggle(wd_w)
  );

  // unit status bundle
  always_comb begin
    unit_w.pu_ready = PU_READY;
    unit_w.running = RUNNING;
    unit_w.fault = FAULT;
    unit_w.warning = WARNING;
    unit_w.fb_place = FB_PLACE;
    unit_w.run_en = RUN_EN_IN;
  end

  cfsc_state_pack u_state (
    .clk(CLK),
    .rst(RESET),
    .ce(CE),
    .cmd_word(cmd_w),
    .unit(unit_w),
    .state_word(state_w)
  );

  // event reset edge and ready output: next values
  // a held-high bit 7 gives one pulse only; a steady level is ignored
  always_comb begin
    evt_prev_nxt = cmd_w[cfsc_pkg::CB_EVT_RESET];
    evt_pulse_nxt = cmd_w[cfsc_pkg::CB_EVT_RESET] & ~evt_prev_r;
    // same decode and same timing as state bit 0
    ready_nxt = cfsc_pkg::cfsc_ready(cmd_w, FAULT);
  end

  // event reset edge and ready output: registers
  // prev resets to 1 so the default word cannot fake an edge
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_prev_r <= 1'b1;
      evt_pulse_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (CE) begin
      evt_prev_r <= evt_prev_nxt;
      evt_pulse_r <= evt_pulse_nxt;
      ready_r <= ready_nxt;
    end
  end

  // outputs from flip-flops; BREAKER_PERMIT through an AND, QSTOP_REQ through an inverter
  assign CMD_WORD = DATA_W'(cmd_w);
  assign STATE_WORD = DATA_W'(state_w);
  // watchdog bit goes to the supervision outside
  assign WD_TOGGLE = wd_w;
  // vendor functions in bit order from bit 12 up
  assign VENDOR_FN = cmd_w[cfsc_pkg::CB_VEND_LO +: VEND_N];
  // low bit 0 blocks charge, breaker close and running
  assign RUN_PERMIT = cmd_w[cfsc_pkg::CB_SWITCH_ON];
  assign BREAKER_PERMIT = cmd_w[cfsc_pkg::CB_SWITCH_ON] & cmd_w[cfsc_pkg::CB_BREAKER];
  // inverted sense: low bit 2 stops modulation
  assign QSTOP_REQ = ~cmd_w[cfsc_pkg::CB_QSTOP_N];
  assign EVENT_RESET = evt_pulse_r;
  assign READY_OUT = ready_r;

  // checks on the outputs, one clock domain
  default clocking cb_main @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // a cycle in which nothing may change the held bits
  sequence s_quiet;
    CE && !WD_FAULT && !(RX_VALID && RX_WORD[cfsc_pkg::CB_VALID]);
  endsequence

  // bit 7 low then high across two enabled cycles
  sequence s_evt_rise;
    (CE && !CMD_WORD[cfsc_pkg::CB_EVT_RESET]) ##1 (CE && CMD_WORD[cfsc_pkg::CB_EVT_RESET]);
  endsequence

  hold_gate_a: assert property (
    (s_quiet ##1 s_quiet) |=> (CMD_WORD[10:0] == $past(CMD_WORD[10:0]))
      && (CMD_WORD[15:12] == $past(CMD_WORD[15:12])))
    else $error("command word changed without data valid");

  accept_word_a: assert property (
    (CE && RX_VALID && RX_WORD[cfsc_pkg::CB_VALID] && !WD_FAULT) |=> CMD_WORD == $past(RX_WORD))
    else $error("valid word was not applied");

  wdog_take_a: assert property (
    (CE && RX_VALID) |=> (WD_TOGGLE == $past(RX_WORD[cfsc_pkg::CB_WDOG]))
      && (CMD_WORD[cfsc_pkg::CB_WDOG] == $past(RX_WORD[cfsc_pkg::CB_WDOG])))
    else $error("watchdog bit not taken from current word");

  fault_default_a: assert property (
    (CE && WD_FAULT) |=> (CMD_WORD[10:0] == cfsc_pkg::CMD_DEFAULT[10:0])
      && (CMD_WORD[15:12] == cfsc_pkg::CMD_DEFAULT[15:12]))
    else $error("default word not substituted on watchdog fault");

  ready_bit_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_READY] == $past(CMD_WORD[0] && CMD_WORD[1] && CMD_WORD[2] && !FAULT))
    else $error("ready bit wrong");

  ready_out_a: assert property (
    READY_OUT == STATE_WORD[cfsc_pkg::SB_READY])
    else $error("ready output differs from state bit 0");

  unit_bits_a: assert property (
    CE |=> (STATE_WORD[cfsc_pkg::SB_PU_READY] == $past(PU_READY))
      && (STATE_WORD[cfsc_pkg::SB_RUNNING] == $past(RUNNING))
      && (STATE_WORD[cfsc_pkg::SB_FAULT] == $past(FAULT))
      && (STATE_WORD[cfsc_pkg::SB_WARNING] == $past(WARNING)))
    else $error("unit status bits wrong");

  place_run_a: assert property (
    CE |=> (STATE_WORD[cfsc_pkg::SB_FB_PLACE] == $past(FB_PLACE))
      && (STATE_WORD[cfsc_pkg::SB_RUN_EN] == $past(RUN_EN_IN)))
    else $error("control place or run enable bit wrong");

  qstop_inv_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_QSTOP_N] == $past(CMD_WORD[cfsc_pkg::CB_QSTOP_N]))
    else $error("quick stop state bit not inverted sense");

  resv_zero_a: assert property (
    (STATE_WORD & cfsc_pkg::SB_RESV_MASK) == 16'h0000)
    else $error("reserved state bit set");

  wdog_echo_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_WDOG] == $past(CMD_WORD[cfsc_pkg::CB_WDOG]))
    else $error("watchdog echo wrong");

  evt_pulse_a: assert property (
    s_evt_rise |=> EVENT_RESET)
    else $error("rising bit 7 gave no event reset");

  evt_single_a: assert property (
    (CE && EVENT_RESET) |=> !EVENT_RESET)
    else $error("event reset longer than one cycle");

  qstop_req_a: assert property (
    QSTOP_REQ != CMD_WORD[cfsc_pkg::CB_QSTOP_N] && RUN_PERMIT == CMD_WORD[cfsc_pkg::CB_SWITCH_ON])
    else $error("quick stop or permit output wrong");

  // a word that the gate accepts whole, no fault in the way
  sequence s_take;
    CE && RX_VALID && RX_WORD[cfsc_pkg::CB_VALID] && !WD_FAULT;
  endsequence

  // a clean cycle followed by a word without data valid
  sequence s_drop;
    (CE && !WD_FAULT) ##1 (CE && RX_VALID && !RX_WORD[cfsc_pkg::CB_VALID] && !WD_FAULT);
  endsequence

  // an invalid word must leave every bit but 11 alone
  drop_word_a: assert property (
    s_drop |=> (CMD_WORD[10:0] == $past(CMD_WORD[10:0]))
      && (CMD_WORD[15:12] == $past(CMD_WORD[15:12])))
    else $error("invalid word changed the command word");

  // vendor outputs come from bits 12 up of the accepted word
  vend_map_a: assert property (
    s_take |=> VENDOR_FN == $past(RX_WORD[cfsc_pkg::CB_VEND_LO +: VEND_N]))
    else $error("vendor function outputs wrong");

  // run permit follows bit 0 of the accepted word
  run_permit_a: assert property (
    s_take |=> RUN_PERMIT == $past(RX_WORD[cfsc_pkg::CB_SWITCH_ON]))
    else $error("run permit not taken from bit 0");

  // low bit 0 must block both permits
  perm_block_a: assert property (
    !CMD_WORD[cfsc_pkg::CB_SWITCH_ON] |-> !RUN_PERMIT && !BREAKER_PERMIT)
    else $error("permit given while bit 0 low");

  // the supervision sees the same bit as the command word
  wdog_out_a: assert property (
    WD_TOGGLE == CMD_WORD[cfsc_pkg::CB_WDOG])
    else $error("watchdog output differs from command bit 11");

  // the default word also clears the vendor functions
  fault_vend_a: assert property (
    (CE && WD_FAULT) |=> VENDOR_FN == cfsc_pkg::CMD_DEFAULT[cfsc_pkg::CB_VEND_LO +: VEND_N])
    else $error("vendor outputs not defaulted on watchdog fault");

  // a low enable freezes every registered output
  ce_freeze_a: assert property (
    !CE |=> (CMD_WORD == $past(CMD_WORD)) && (STATE_WORD == $past(STATE_WORD))
      && (EVENT_RESET == $past(EVENT_RESET)) && (READY_OUT == $past(READY_OUT))
      && (WD_TOGGLE == $past(WD_TOGGLE)))
    else $error("state changed while clock enable low");

  // an active fault removes readiness
  fault_ready_a: assert property (
    (CE && FAULT) |=> !STATE_WORD[cfsc_pkg::SB_READY] && !READY_OUT)
    else $error("ready shown with active fault");

  // a quick stop request removes readiness and shows in bit 5
  qstop_ready_a: assert property (
    (CE && !CMD_WORD[cfsc_pkg::CB_QSTOP_N]) |=> !STATE_WORD[cfsc_pkg::SB_READY]
      && !STATE_WORD[cfsc_pkg::SB_QSTOP_N])
    else $error("ready or quick stop bit wrong under quick stop");

  // modulating flag straight through
  run_bit_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_RUNNING] == $past(RUNNING))
    else $error("running bit wrong");

  // fault flag straight through
  fault_bit_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_FAULT] == $past(FAULT))
    else $error("fault bit wrong");

  // warning flag straight through
  warn_bit_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_WARNING] == $past(WARNING))
    else $error("warning bit wrong");

  // run-enable input straight through
  run_en_bit_a: assert property (
    CE |=> STATE_WORD[cfsc_pkg::SB_RUN_EN] == $past(RUN_EN_IN))
    else $error("run enable bit wrong");

  // a low bit 7 can never start an event reset
  evt_steady_a: assert property (
    (CE && !CMD_WORD[cfsc_pkg::CB_EVT_RESET]) |=> !EVENT_RESET)
    else $error("event reset without bit 7");

endmodule

// ### inc/cfsc_pkg.sv
// Purpose: shared constants, carrier types and decode helpers for the
//          fieldbus command/state word block
// Assumes: 16-bit process data words, one clock domain
// Notes:   bit positions are indices into the command and state words
package cfsc_pkg;

  // word geometry
  localparam int WORD_W = 16;
  localparam int VEND_W = 4;

  // command word reset and substitute value
  localparam logic [15:0] CMD_DEFAULT = 16'h0005;
  // state word value after reset
  localparam logic [15:0] STATE_RESET = 16'h0000;

  // command word field positions
  localparam int CB_SWITCH_ON = 0;
  localparam int CB_BREAKER = 1;
  localparam int CB_QSTOP_N = 2;
  localparam int CB_EVT_RESET = 7;
  localparam int CB_VALID = 10;
  localparam int CB_WDOG = 11;
  localparam int CB_VEND_LO = 12;

  // state word field positions
  localparam int SB_READY = 0;
  localparam int SB_PU_READY = 1;
  localparam int SB_RUNNING = 2;
  localparam int SB_FAULT = 3;
  localparam int SB_QSTOP_N = 5;
  localparam int SB_WARNING = 7;
  localparam int SB_FB_PLACE = 9;
  localparam int SB_RUN_EN = 11;
  localparam int SB_WDOG = 15;

  // reserved state bits 4,6,8,10,12,13,14
  localparam logic [15:0] SB_RESV_MASK = 16'h7550;

  // unit status carried into the state word
  typedef struct packed {
    logic pu_ready;  // power unit can run
    logic running;   // modulating
    logic fault;     // any fault-level event
    logic warning;   // any warning-level event
    logic fb_place;  // fieldbus is control place
    logic run_en;    // dedicated run-enable input
  } cfsc_unit_t;

  // ready to start the pre-charge / breaker sequence
  function automatic logic cfsc_ready(input logic [15:0] cmd, input logic fault);
    cfsc_ready = cmd[CB_SWITCH_ON] & cmd[CB_BREAKER] & cmd[CB_QSTOP_N] & ~fault;
  endfunction

endpackage

// ### hw/cfsc_cmd_gate.sv
// Purpose: data-valid gating of the received command word
// Assumes: rx_valid marks one received word per cycle
// Notes:   watchdog bit bypasses the gate and the fault substitution
`timescale 1ns/1ps
module cfsc_cmd_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rx_valid,
  input wire logic [15:0] rx_word,
  input wire logic wd_fault,
  output logic [15:0] cmd_word,
  output logic wd_toggle
);

  logic [15:0] held_r;   // last accepted word
  logic [15:0] held_nxt;
  logic wd_r;            // latest received watchdog bit
  logic wd_nxt;
  logic [15:0] cmd_r;    // effective word seen by the unit
  logic [15:0] cmd_nxt;

  // next values
  always_comb begin
    held_nxt = held_r;
    wd_nxt = wd_r;
    if (rx_valid) begin
      wd_nxt = rx_word[cfsc_pkg::CB_WDOG];
      if (rx_word[cfsc_pkg::CB_VALID]) begin
        held_nxt = rx_word;
      end
    end
    // fault forces the default but the held word survives it
    cmd_nxt = wd_fault ? cfsc_pkg::CMD_DEFAULT : held_nxt;
    cmd_nxt[cfsc_pkg::CB_WDOG] = wd_nxt;
  end

  // registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_r <= cfsc_pkg::CMD_DEFAULT;
      wd_r <= 1'b0;
      cmd_r <= cfsc_pkg::CMD_DEFAULT;
    end else if (ce) begin
      held_r <= held_nxt;
      wd_r <= wd_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  assign cmd_word = cmd_r;
  assign wd_toggle = wd_r;

endmodule

// ### hw/cfsc_state_pack.sv
// Purpose: builds the registered 16-bit state word
// Assumes: cmd_word is the effective command word
// Notes:   one cycle from inputs to state word
`timescale 1ns/1ps
module cfsc_state_pack (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] cmd_word,
  input wire cfsc_pkg::cfsc_unit_t unit,
  output logic [15:0] state_word
);

  logic [15:0] state_r;
  logic [15:0] state_nxt;

  // assemble fields; untouched bits stay zero
  always_comb begin
    state_nxt = 16'h0000;
    state_nxt[cfsc_pkg::SB_READY] = cfsc_pkg::cfsc_ready(cmd_word, unit.fault);
    state_nxt[cfsc_pkg::SB_PU_READY] = unit.pu_ready;
    state_nxt[cfsc_pkg::SB_RUNNING] = unit.running;
    state_nxt[cfsc_pkg::SB_FAULT] = unit.fault;
    state_nxt[cfsc_pkg::SB_QSTOP_N] = cmd_word[cfsc_pkg::CB_QSTOP_N];
    state_nxt[cfsc_pkg::SB_WARNING] = unit.warning;
    state_nxt[cfsc_pkg::SB_FB_PLACE] = unit.fb_place;
    state_nxt[cfsc_pkg::SB_RUN_EN] = unit.run_en;
    state_nxt[cfsc_pkg::SB_WDOG] = cmd_word[cfsc_pkg::CB_WDOG];
  end

  // register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= cfsc_pkg::STATE_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign state_word = state_r;

endmodule

// ### testbench/cfsc_master_model.sv
// Purpose: fieldbus master model that sends command words
// Assumes: one word per call, changed just after the rising edge
// Notes:   idle data lines show the inverse of the last word
`timescale 1ns/1ps
module cfsc_master_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [15:0] rx_word
);
  logic [15:0] last_w; // last word sent

  // idle at time zero
  initial begin
    rx_valid = 1'b0;
    rx_word = 16'h0000;
    last_w = 16'h0000;
  end

  // one word per call, bit 11 is the master's own watchdog toggle
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_word <= w;
    last_w = w;
    @(posedge clk);
    rx_valid <= 1'b0;
    // released lines must not look like a held word
    rx_word <= ~last_w;
  endtask
endmodule

// ### testbench/cfsc_top_tb.sv
// Purpose: self-checking bench for command intake and state word
// Assumes: CE high except in the clock enable test, inputs changed just after the rising edge
// Notes:   expected words are built here from the bit map
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cfsc_top_tb;
  logic clk, reset, ce, wd_fault, rx_valid;
  logic [15:0] rx_word, cmd_word, state_word;
  logic wd_toggle, run_permit, brk_permit, qstop_req, evt_reset, ready_out;
  logic [3:0] vendor_fn;
  cfsc_pkg::cfsc_unit_t unit_r; // unit status inputs
  int bad_count = 0;
  int n_checks = 0;

  cfsc_master_model m_u (.clk(clk), .rx_valid(rx_valid), .rx_word(rx_word));

  cfsc_top dut_u (.CLK(clk), .RESET(reset), .CE(ce), .RX_VALID(rx_valid), .RX_WORD(rx_word),
    .WD_FAULT(wd_fault), .PU_READY(unit_r.pu_ready), .RUNNING(unit_r.running),
    .FAULT(unit_r.fault), .WARNING(unit_r.warning), .FB_PLACE(unit_r.fb_place),
    .RUN_EN_IN(unit_r.run_en), .CMD_WORD(cmd_word), .STATE_WORD(state_word),
    .WD_TOGGLE(wd_toggle), .VENDOR_FN(vendor_fn), .RUN_PERMIT(run_permit),
    .BREAKER_PERMIT(brk_permit), .QSTOP_REQ(qstop_req), .EVENT_RESET(evt_reset),
    .READY_OUT(ready_out));

  // expected state word from command word and unit status
  function automatic logic [15:0] exp_st(input logic [15:0] c, input cfsc_pkg::cfsc_unit_t u);
    logic [15:0] s;
    s = 16'h0000;
    s[0] = c[0] & c[1] & c[2] & ~u.fault;
    s[1] = u.pu_ready;
    s[2] = u.running;
    s[3] = u.fault;
    s[5] = c[2];
    s[7] = u.warning;
    s[9] = u.fb_place;
    s[11] = u.run_en;
    s[15] = c[11];
    return s;
  endfunction

  // counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard, far beyond the 55 or so cycles of the tests
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    wd_fault = 1'b0;
    unit_r = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK("cmd in reset", 16'h0005, cmd_word)
    `CHK("state in reset", 16'h0000, state_word)
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK("state default", exp_st(16'h0005, unit_r), state_word)
    $display("test reset done");
    // valid word, bit 7 rises
    m_u.send(16'h048F);
    @(negedge clk);
    `CHK("cmd valid", 16'h048F, cmd_word)
    `CHK("brk permit", 1'b1, brk_permit)
    `CHK("qstop off", 1'b0, qstop_req)
    @(negedge clk);
    `CHK("evt pulse", 1'b1, evt_reset)
    `CHK("ready", exp_st(16'h048F, unit_r), state_word)
    `CHK("ready out", 1'b1, ready_out)
    @(negedge clk);
    `CHK("evt once", 1'b0, evt_reset)
    // invalid word keeps all but the watchdog bit
    m_u.send(16'h0800);
    @(negedge clk);
    `CHK("cmd held", 16'h0C8F, cmd_word)
    `CHK("wd toggle", 1'b1, wd_toggle)
    @(negedge clk);
    `CHK("wd echo", exp_st(16'h0C8F, unit_r), state_word)
    `CHK("steady bit7", 1'b0, evt_reset)
    // watchdog fault substitutes the default
    @(posedge clk);
    wd_fault <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("cmd wd fault", 16'h0805, cmd_word)
    @(posedge clk);
    wd_fault <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK("cmd restored", 16'h0C8F, cmd_word)
    $display("test gating done");
    // each vendor bit on its own, back to back
    for (int i = 0; i < 4; i++) begin
      m_u.send(16'h0407 | (16'h1000 << i));
      @(negedge clk);
      `CHK("vendor", 4'(1 << i), vendor_fn)
    end
    // quick stop and bit 7 rising again
    m_u.send(16'h0483);
    @(negedge clk);
    `CHK("qstop on", 1'b1, qstop_req)
    @(negedge clk);
    `CHK("evt again", 1'b1, evt_reset)
    `CHK("qstop state", exp_st(16'h0483, unit_r), state_word)
    m_u.send(16'h0400);
    @(negedge clk);
    `CHK("run blocked", 1'b0, run_permit)
    `CHK("brk blocked", 1'b0, brk_permit)
    $display("test command bits done");
    // unit status inputs one at a time
    m_u.send(16'h0407);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      unit_r <= cfsc_pkg::cfsc_unit_t'(6'(1 << i));
      @(posedge clk);
      @(negedge clk);
      `CHK("state unit", exp_st(16'h0407, unit_r), state_word)
      `CHK("ready match", state_word[0], ready_out)
    end
    $display("test status bits done");
    // clock enable low drops the word and freezes the outputs
    @(posedge clk);
    ce <= 1'b0;
    m_u.send(16'h048F);
    @(negedge clk);
    `CHK("ce freeze cmd", 16'h0407, cmd_word)
    `CHK("ce freeze evt", 1'b0, evt_reset)
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("ce resume cmd", 16'h0407, cmd_word)
    $display("test clock enable done");
    // reset in mid-run
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK("rerun cmd", 16'h0005, cmd_word)
    `CHK("rerun state", 16'h0000, state_word)
    `CHK("rerun ready", 1'b0, ready_out)
    `CHK("rerun evt", 1'b0, evt_reset)
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK("rerun default", exp_st(16'h0005, unit_r), state_word)
    `CHK("rerun no evt", 1'b0, evt_reset)
    $display("test mid reset done");
    test_done();
  end
endmodule
